/* hdl/usi_pkg.sv */
// Constants shared by the serial status and interrupt-enable slice
`default_nettype none
package usi_pkg;
  // Frame format widths
  localparam int unsigned DATA_BITS_8 = 8;
  localparam int unsigned DATA_BITS_9 = 9;
  // Reset values of status and enable bits
  localparam logic RST_NINTH = 1'h0;
  localparam logic RST_TX_ACTIVE = 1'h0;
  localparam logic RST_IRQ_EN = 1'h0;
  localparam logic RST_ERR_SUM = 1'h0;
  // Bit positions within the error flag vector
  localparam int unsigned ERR_PARITY = 0;
  localparam int unsigned ERR_FRAMING = 1;
  localparam int unsigned ERR_OVERRUN = 2;
  localparam int unsigned ERR_COUNT = 3;
  // Transmit tracker states, Gray coded
  typedef enum logic [1:0] {
    USI_TX_IDLE = 2'h0,
    USI_TX_SHIFT = 2'h1,
    USI_TX_LAST = 2'h3
  } usi_tx_e;
endpackage
`default_nettype wire

/* hdl/usi_status_irq.sv */
// Status flags and interrupt enables of the serial port
`timescale 1ns/1ps
`default_nettype none
module usi_status_irq (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // Receive side
  input wire logic NINE_BIT_MODE_I,
  input wire logic RX_CHAR_DONE_I,
  input wire logic RX_BIT8_I,
  input wire logic RX_FULL_FLAG_I,
  input wire logic PARITY_ERR_FLAG_I,
  input wire logic FRAMING_ERR_FLAG_I,
  input wire logic OVERRUN_ERR_FLAG_I,
  // Transmit side
  input wire logic TX_START_I,
  input wire logic TX_LAST_BIT_I,
  input wire logic TX_BIT_DONE_I,
  input wire logic TX_MORE_I,
  input wire logic TX_EMPTY_I,
  // Enable writes from software
  input wire logic EN_WR_I,
  input wire logic TX_EMPTY_IRQ_EN_I,
  input wire logic RX_FULL_IRQ_EN_I,
  input wire logic RX_ERR_IRQ_EN_I,
  // Status back to software
  output logic RX_NINTH_BIT_O,
  output logic TX_ACTIVE_FLAG_O,
  output logic RX_ERROR_SUMMARY_O,
  output logic TX_EMPTY_IRQ_EN_O,
  output logic RX_FULL_IRQ_EN_O,
  output logic RX_ERR_IRQ_EN_O,
  // Interrupt requests
  output logic TX_EMPTY_IRQ_O,
  output logic RX_FULL_IRQ_O,
  output logic RX_ERR_IRQ_O
);

  // Tracker state and its next value
  usi_pkg::usi_tx_e tx_state;
  usi_pkg::usi_tx_e next_tx_state;
  // Error flags gathered at their fixed positions
  logic [usi_pkg::ERR_COUNT-1:0] err_flags;

  assign err_flags[usi_pkg::ERR_PARITY] = PARITY_ERR_FLAG_I;
  assign err_flags[usi_pkg::ERR_FRAMING] = FRAMING_ERR_FLAG_I;
  assign err_flags[usi_pkg::ERR_OVERRUN] = OVERRUN_ERR_FLAG_I;

  // Capture decode, shared by the flag and its checks
  function automatic logic ninth_take(input logic done, input logic nine);
    return done & nine;
  endfunction

  // Ninth bit captured per character in nine-bit mode; held otherwise so software sees the last one
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      RX_NINTH_BIT_O <= usi_pkg::RST_NINTH;
    end else if (ninth_take(RX_CHAR_DONE_I, NINE_BIT_MODE_I)) begin
      RX_NINTH_BIT_O <= RX_BIT8_I;
    end
  end

  // Transmit tracker: idle, shifting, final bit of the last frame
  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      usi_pkg::USI_TX_IDLE: begin
        if (TX_START_I) begin
          next_tx_state = usi_pkg::USI_TX_SHIFT;
        end
      end
      usi_pkg::USI_TX_SHIFT: begin
        if (TX_LAST_BIT_I && !TX_MORE_I) begin
          next_tx_state = usi_pkg::USI_TX_LAST;
        end
      end
      usi_pkg::USI_TX_LAST: begin
        // A back-to-back frame keeps the flag up without a gap
        if (TX_MORE_I || TX_START_I) begin
          next_tx_state = usi_pkg::USI_TX_SHIFT;
        end else if (TX_BIT_DONE_I) begin
          next_tx_state = usi_pkg::USI_TX_IDLE;
        end
      end
      default: begin
        next_tx_state = usi_pkg::USI_TX_IDLE;
      end
    endcase
  end

  // State register and flag from flip-flops
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      tx_state <= usi_pkg::USI_TX_IDLE;
      TX_ACTIVE_FLAG_O <= usi_pkg::RST_TX_ACTIVE;
    end else begin
      tx_state <= next_tx_state;
      TX_ACTIVE_FLAG_O <= (next_tx_state != usi_pkg::USI_TX_IDLE);
    end
  end

  // Summary follows the three error flags with one cycle of latency
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      RX_ERROR_SUMMARY_O <= usi_pkg::RST_ERR_SUM;
    end else begin
      RX_ERROR_SUMMARY_O <= |err_flags;
    end
  end

  // Enable bits written by software
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      TX_EMPTY_IRQ_EN_O <= usi_pkg::RST_IRQ_EN;
      RX_FULL_IRQ_EN_O <= usi_pkg::RST_IRQ_EN;
      RX_ERR_IRQ_EN_O <= usi_pkg::RST_IRQ_EN;
    end else if (EN_WR_I) begin
      TX_EMPTY_IRQ_EN_O <= TX_EMPTY_IRQ_EN_I;
      RX_FULL_IRQ_EN_O <= RX_FULL_IRQ_EN_I;
      RX_ERR_IRQ_EN_O <= RX_ERR_IRQ_EN_I;
    end
  end

  // Level requests, combinational so they drop the cycle a source, the registered error summary or an enable falls
  assign TX_EMPTY_IRQ_O = TX_EMPTY_IRQ_EN_O & TX_EMPTY_I;
  assign RX_FULL_IRQ_O = RX_FULL_IRQ_EN_O & RX_FULL_FLAG_I;
  assign RX_ERR_IRQ_O = RX_ERR_IRQ_EN_O & RX_ERROR_SUMMARY_O;

  a_ninth_capture: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    ninth_take(RX_CHAR_DONE_I, NINE_BIT_MODE_I) |=> RX_NINTH_BIT_O == $past(RX_BIT8_I))
    else $error("ninth bit not captured");

  a_ninth_hold: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    !ninth_take(RX_CHAR_DONE_I, NINE_BIT_MODE_I) |=> $stable(RX_NINTH_BIT_O))
    else $error("ninth bit changed without a character");

  a_tx_start_flag: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    tx_state == usi_pkg::USI_TX_IDLE && TX_START_I |=> TX_ACTIVE_FLAG_O)
    else $error("transmit flag not set on start");

  a_tx_idle_flag: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    TX_ACTIVE_FLAG_O == (tx_state != usi_pkg::USI_TX_IDLE))
    else $error("transmit flag disagrees with tracker");

  a_tx_clear_end: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    $fell(TX_ACTIVE_FLAG_O) |-> $past(tx_state == usi_pkg::USI_TX_LAST && TX_BIT_DONE_I))
    else $error("transmit flag cleared before last bit");

  a_tx_empty_irq: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    TX_EMPTY_IRQ_O == (TX_EMPTY_IRQ_EN_O && TX_EMPTY_I))
    else $error("transmit empty request wrong");

  a_rx_full_irq: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    EN_WR_I && RX_FULL_IRQ_EN_I ##1 RX_FULL_FLAG_I |-> RX_FULL_IRQ_O)
    else $error("receive full request missing");

  a_err_irq_path: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    RX_ERR_IRQ_EN_O && $past(|err_flags) |-> RX_ERR_IRQ_O)
    else $error("receive error request missing");

  a_err_summary: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (PARITY_ERR_FLAG_I || FRAMING_ERR_FLAG_I || OVERRUN_ERR_FLAG_I) |=> RX_ERROR_SUMMARY_O)
    else $error("error summary not set");

  a_err_clear: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    !(PARITY_ERR_FLAG_I || FRAMING_ERR_FLAG_I || OVERRUN_ERR_FLAG_I) |=> !RX_ERROR_SUMMARY_O)
    else $error("error summary not cleared");

  a_irq_level_drop: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    !RX_FULL_IRQ_EN_O || !RX_FULL_FLAG_I |-> !RX_FULL_IRQ_O)
    else $error("receive full request stuck");

  // Reset, enable-write, transmit-flag and level checks
  a_reset_quiet: assert property (@(posedge MCLK_I)
    SRST_I |=> !TX_ACTIVE_FLAG_O && !RX_ERROR_SUMMARY_O && !RX_NINTH_BIT_O)
    else $error("status not cleared by reset");

  a_reset_irq_off: assert property (@(posedge MCLK_I)
    SRST_I |=> !TX_EMPTY_IRQ_O && !RX_FULL_IRQ_O && !RX_ERR_IRQ_O)
    else $error("request raised after reset");

  a_tx_en_write: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    EN_WR_I |=> TX_EMPTY_IRQ_EN_O == $past(TX_EMPTY_IRQ_EN_I))
    else $error("transmit empty enable not written");

  a_rx_en_write: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    EN_WR_I |=> RX_FULL_IRQ_EN_O == $past(RX_FULL_IRQ_EN_I))
    else $error("receive full enable not written");

  a_err_en_write: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    EN_WR_I |=> RX_ERR_IRQ_EN_O == $past(RX_ERR_IRQ_EN_I))
    else $error("receive error enable not written");

  a_en_hold: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    !EN_WR_I |=> $stable({TX_EMPTY_IRQ_EN_O, RX_FULL_IRQ_EN_O, RX_ERR_IRQ_EN_O}))
    else $error("enable changed without a write");

  a_tx_shift_flag: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    tx_state == usi_pkg::USI_TX_SHIFT |=> TX_ACTIVE_FLAG_O)
    else $error("transmit flag dropped while shifting");

  a_tx_last_hold: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    tx_state == usi_pkg::USI_TX_LAST && !TX_BIT_DONE_I |=> TX_ACTIVE_FLAG_O)
    else $error("transmit flag dropped during last bit");

  a_rx_full_level: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    RX_FULL_IRQ_O == (RX_FULL_IRQ_EN_O && RX_FULL_FLAG_I))
    else $error("receive full request wrong");

  a_err_irq_level: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    RX_ERR_IRQ_O == (RX_ERR_IRQ_EN_O && RX_ERROR_SUMMARY_O))
    else $error("receive error request wrong");

endmodule
`default_nettype wire

/* test/usi_tx_peer.sv */
// Transmitter sequencing model facing the status slice
`timescale 1ns/1ps
`default_nettype none
module usi_tx_peer (
  // Clock
  input wire logic clk_i,
  // Transmit sequencing
  output logic start_o,
  output logic last_bit_o,
  output logic bit_done_o,
  output logic more_o
);
  initial {start_o, last_bit_o, bit_done_o, more_o} = 4'h0;
  // One frame, all moves on falling edges; last bit held a cycle before done
  task automatic send_frame(input int bits, input logic more);
    start_o = 1'h1;
    @(negedge clk_i) start_o = 1'h0;
    // A quiet cycle between bit pulses keeps each one a single-cycle strobe
    repeat (bits) begin
      bit_done_o = 1'h1;
      @(negedge clk_i) bit_done_o = 1'h0;
      @(negedge clk_i);
    end
    last_bit_o = 1'h1;
    more_o = more;
    @(negedge clk_i) bit_done_o = 1'h1;
    @(negedge clk_i) {last_bit_o, bit_done_o, more_o} = 3'h0;
  endtask
endmodule
`default_nettype wire

/* test/usi_status_irq_tb.sv */
// Self-checking bench for the serial status and interrupt-enable slice
`timescale 1ns/1ps
`default_nettype none
module usi_status_irq_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic nine, cd, b8, rxf, pe, fe, oe, txe, wr, etx, erx, eer, st, lb, bd, mo;
  logic nb, ta, sum, o_etx, o_erx, o_eer, q_tx, q_rx, q_er;
  logic m_nb, m_sum, m_etx, m_erx, m_eer;
  int miscompares = 0;
  int check_count = 0;
  initial forever #4 clk = ~clk;
  usi_tx_peer i_peer (.clk_i(clk), .start_o(st), .last_bit_o(lb), .bit_done_o(bd), .more_o(mo));
  usi_status_irq i_dut (.MCLK_I(clk), .SRST_I(rst), .NINE_BIT_MODE_I(nine),
    .RX_CHAR_DONE_I(cd), .RX_BIT8_I(b8), .RX_FULL_FLAG_I(rxf), .PARITY_ERR_FLAG_I(pe),
    .FRAMING_ERR_FLAG_I(fe), .OVERRUN_ERR_FLAG_I(oe), .TX_START_I(st), .TX_LAST_BIT_I(lb),
    .TX_BIT_DONE_I(bd), .TX_MORE_I(mo), .TX_EMPTY_I(txe), .EN_WR_I(wr),
    .TX_EMPTY_IRQ_EN_I(etx), .RX_FULL_IRQ_EN_I(erx), .RX_ERR_IRQ_EN_I(eer),
    .RX_NINTH_BIT_O(nb), .TX_ACTIVE_FLAG_O(ta), .RX_ERROR_SUMMARY_O(sum),
    .TX_EMPTY_IRQ_EN_O(o_etx), .RX_FULL_IRQ_EN_O(o_erx), .RX_ERR_IRQ_EN_O(o_eer),
    .TX_EMPTY_IRQ_O(q_tx), .RX_FULL_IRQ_O(q_rx), .RX_ERR_IRQ_O(q_er));
  // Level request expected from enable and source
  function automatic logic irq(input logic en, input logic src);
    return en & src;
  endfunction
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    {nine, cd, b8, rxf, pe, fe, oe, txe, wr, etx, erx, eer} = 12'h000;
    {m_nb, m_sum, m_etx, m_erx, m_eer} = 5'h00;
    void'($urandom(32'h8143));
    repeat (10) @(negedge clk);
    rst = 1'h0;
    // Random traffic; model updated from inputs the last rising edge saw
    repeat (400) begin
      @(negedge clk);
      if (wr) {m_etx, m_erx, m_eer} = {etx, erx, eer};
      if (cd && nine) m_nb = b8;
      m_sum = pe | fe | oe;
      check("ninth", nb, m_nb);
      check("err_sum", sum, m_sum);
      check("enables", {o_etx, o_erx, o_eer}, {m_etx, m_erx, m_eer});
      check("tx_irq", q_tx, irq(m_etx, txe));
      check("rx_irq", q_rx, irq(m_erx, rxf));
      check("err_irq", q_er, irq(m_eer, m_sum));
      check("tx_idle", ta, 1'h0);
      {nine, cd, b8, rxf, pe, fe, oe, txe, wr, etx, erx, eer} = 12'($urandom);
      {pe, fe, oe} = 3'($urandom & $urandom & $urandom);
    end
    // Back-to-back frames: flag must hold across the join
    fork
      begin
        i_peer.send_frame(3, 1'h1);
        i_peer.send_frame(2, 1'h0);
      end
      repeat (15) begin
        @(negedge clk);
        check("tx_busy", ta, 1'h1);
      end
    join
    check("tx_done", ta, 1'h0);
    // Mid-run reset clears every stored bit
    rst = 1'h1;
    {cd, pe, fe, oe, wr} = 5'h00;
    @(negedge clk);
    check("rst_state", {nb, sum, o_etx | o_erx | o_eer}, 3'h0);
    check("rst_quiet", {ta, q_tx | q_rx, q_er}, 3'h0);
    // Release with a write waiting: the first edge after reset must take it
    rst = 1'h0;
    {wr, etx, erx, eer, txe, rxf} = 6'h3F;
    @(negedge clk);
    check("post_rst_en", {o_etx, o_erx, o_eer}, 3'h7);
    check("post_rst_irq", {q_tx, q_rx, q_er}, 3'h6);
    final_report();
  end
endmodule
`default_nettype wire
